// ==== core/ionf_cfg.svh ====
`ifndef IONF_CFG_SVH
`define IONF_CFG_SVH

// Register offsets (byte addresses, one word each)
`define IONF_OFF_CTRL     8'h00
`define IONF_OFF_STATUS   8'h04
`define IONF_OFF_RELAY    8'h08
`define IONF_OFF_RBACK    8'h0C
`define IONF_OFF_DIN      8'h10
`define IONF_OFF_DAC      8'h14
`define IONF_OFF_ADC      8'h18
`define IONF_OFF_VFC      8'h1C
`define IONF_OFF_ADDR     8'h20
`define IONF_OFF_CFG      8'h24
`define IONF_OFF_ID       8'h28

// CTRL bit positions (write only, self clearing)
`define IONF_CTRL_HOSTRST 0
`define IONF_CTRL_CONFL   1
`define IONF_CTRL_PFAULT  2
`define IONF_CTRL_CMD     3

// CFG reset value: expected node address and module type
`define IONF_CFG_RST      32'h0000_0000

// Module type codes
`define IONF_TYPE_DIN     3'h0
`define IONF_TYPE_AIN     3'h1
`define IONF_TYPE_RELAY   3'h2
`define IONF_TYPE_AOUT    3'h3

// Watchdog timeout
`define IONF_WD_MS        1200
`define IONF_CLK_MHZ      250
`define IONF_WD_CYC       (`IONF_WD_MS * 1000 * `IONF_CLK_MHZ)

// Fault indicator blink half period
`define IONF_BLINK_MS     250
`define IONF_BLINK_CYC    (`IONF_BLINK_MS * 1000 * `IONF_CLK_MHZ)

// Reference check window on the converter period count
`define IONF_REF_LO       16'h0400
`define IONF_REF_HI       16'h0C00

`endif

// ==== core/ionf_pkg.sv ====
package ionf_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ionf_bus_t;

  typedef struct packed {
    logic        drv_en;
    logic [7:0]  relay;
    logic        stat_led;
    logic [15:0] dac;
    logic        fault_led;
  } ionf_out_t;

  typedef enum logic [1:0] {
    IONF_INIT,
    IONF_RUN,
    IONF_HALT
  } ionf_state_t;

endpackage : ionf_pkg

// ==== core/ionf_node.sv ====
`timescale 1ns/1ps
// What this block does
// - Address sampled once after power-up or host reset
// - Address mismatch keeps node silent
// - Duplicate address stops node functioning
// - Wrong-type command leaves outputs unchanged
// - Relay watchdog disables drivers after 1.2s
// - Relay node halts until power/host reset
// - Current watchdog disables drivers after 1.2s
// - Current node halts until power/host reset
// - Each matching-type relay command loads relay shift register while running with no timeout or conflict pending
// - Relay readback compared per relay
// - Current readback and status to host
// - Sixteen discrete inputs captured for host
// - Converter period measured into count
// - Reference check failure reported as fault
// - Fault indicator off normal, lit/blinks faulted
`include "ionf_cfg.svh"
module ionf_node #(
  parameter int unsigned WD_CYC    = `IONF_WD_CYC,
  parameter int unsigned BLINK_CYC = `IONF_BLINK_CYC
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire ionf_pkg::ionf_bus_t bus,
  output logic [31:0]           rdata,
  input  wire logic [7:0]       addr_sw,
  input  wire logic [7:0]       relay_rb,
  input  wire logic [15:0]      din,
  input  wire logic [15:0]      adc_val,
  input  wire logic             vfc_in,
  input  wire logic             vfc_ref_sel,
  output ionf_pkg::ionf_out_t   outs,
  output logic                  comm_en
);
  import ionf_pkg::*;

  ionf_state_t st_r, st_nxt;
  logic [7:0]  node_addr_r, node_addr_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  logic [7:0]  relay_r, relay_nxt;
  logic [15:0] dac_r, dac_nxt;
  logic [15:0] din_r, din_nxt;
  logic [7:0]  rb_err_r, rb_err_nxt;
  logic        conflict_r, conflict_nxt;
  logic        pfault_r, pfault_nxt;
  logic        ref_fail_r, ref_fail_nxt;
  logic        drv_en_r, drv_en_nxt;
  logic        stat_led_r, stat_led_nxt;
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic        wd_to_r, wd_to_nxt;
  logic [15:0] per_cnt_r, per_cnt_nxt;
  logic [15:0] count_r, count_nxt;
  logic        vfc_d_r, vfc_d_nxt;
  logic [31:0] blink_cnt_r, blink_cnt_nxt;
  logic        blink_r, blink_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic [2:0]  mod_type;
  logic [7:0]  exp_addr;
  logic        host_rst, cmd_wr, type_ok, is_out, running, mismatch;

  assign exp_addr = cfg_r[7:0];
  assign mod_type = cfg_r[10:8];
  assign is_out   = (mod_type == `IONF_TYPE_RELAY) || (mod_type == `IONF_TYPE_AOUT);
  assign host_rst = bus.wr && bus.addr == `IONF_OFF_CTRL && bus.wdata[`IONF_CTRL_HOSTRST];
  assign mismatch = node_addr_r != exp_addr;
  assign running  = st_r == IONF_RUN;
  // Command carries its target type in bits 18:16
  assign cmd_wr   = bus.wr && running && (bus.addr == `IONF_OFF_RELAY ||
                    bus.addr == `IONF_OFF_DAC);
  assign type_ok  = bus.wdata[18:16] == mod_type;

  always_comb begin
    st_nxt        = st_r;
    node_addr_nxt = node_addr_r;
    cfg_nxt       = cfg_r;
    relay_nxt     = relay_r;
    dac_nxt       = dac_r;
    conflict_nxt  = conflict_r;
    pfault_nxt    = pfault_r;
    drv_en_nxt    = drv_en_r;
    stat_led_nxt  = stat_led_r;
    wd_cnt_nxt    = wd_cnt_r;
    wd_to_nxt     = wd_to_r;
    case (st_r)
      IONF_INIT: begin
        // Switches read once, later changes ignored
        node_addr_nxt = addr_sw;
        st_nxt        = IONF_RUN;
        drv_en_nxt    = 1'b1;
      end
      IONF_RUN: begin
        if (conflict_r) begin
          st_nxt     = IONF_HALT;
          drv_en_nxt = 1'b0;
        end else if (is_out && wd_to_r) begin
          st_nxt     = IONF_HALT;
          drv_en_nxt = 1'b0;
          relay_nxt  = 8'h00;
          dac_nxt    = 16'h0000;
        end
        // A late command must not undo the forced-off outputs
        if (cmd_wr && type_ok && !wd_to_r && !conflict_r) begin
          wd_cnt_nxt = 32'h0000_0000;
          if (bus.addr == `IONF_OFF_RELAY) begin
            relay_nxt    = bus.wdata[7:0];
            stat_led_nxt = bus.wdata[8];
          end else begin
            dac_nxt = bus.wdata[15:0];
          end
        end else if (is_out && !wd_to_r) begin
          if (wd_cnt_r >= WD_CYC - 1) begin
            wd_to_nxt = 1'b1;
          end else begin
            wd_cnt_nxt = wd_cnt_r + 32'h0000_0001;
          end
        end
      end
      IONF_HALT: begin
        drv_en_nxt = 1'b0;
      end
      default: st_nxt = IONF_INIT;
    endcase
    if (bus.wr && bus.addr == `IONF_OFF_CFG) begin
      cfg_nxt = bus.wdata;
    end
    // Host reset restarts the node and rereads the switches
    if (host_rst) begin
      st_nxt       = IONF_INIT;
      wd_cnt_nxt   = 32'h0000_0000;
      wd_to_nxt    = 1'b0;
      conflict_nxt = 1'b0;
      pfault_nxt   = 1'b0;
      relay_nxt    = 8'h00;
      dac_nxt      = 16'h0000;
      drv_en_nxt   = 1'b0;
    end
    // Set wins over a host reset in the same write
    if (bus.wr && bus.addr == `IONF_OFF_CTRL) begin
      if (bus.wdata[`IONF_CTRL_CONFL]) conflict_nxt = 1'b1;
      if (bus.wdata[`IONF_CTRL_PFAULT]) pfault_nxt = 1'b1;
    end
  end

  // Readback, inputs and converter period measurement
  always_comb begin
    din_nxt      = din;
    rb_err_nxt   = relay_rb ^ relay_r;
    vfc_d_nxt    = vfc_in;
    per_cnt_nxt  = per_cnt_r;
    count_nxt    = count_r;
    ref_fail_nxt = ref_fail_r;
    if (host_rst) ref_fail_nxt = 1'b0;
    if (vfc_in && !vfc_d_r) begin
      count_nxt   = per_cnt_r;
      per_cnt_nxt = 16'h0001;
      if (vfc_ref_sel) begin
        ref_fail_nxt = per_cnt_r < `IONF_REF_LO || per_cnt_r > `IONF_REF_HI;
      end
    end else if (per_cnt_r != 16'hFFFF) begin
      per_cnt_nxt = per_cnt_r + 16'h0001;
    end
  end

  // Blink divider for the fault indicator
  always_comb begin
    blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
    blink_nxt     = blink_r;
    if (blink_cnt_r >= BLINK_CYC - 1) begin
      blink_cnt_nxt = 32'h0000_0000;
      blink_nxt     = !blink_r;
    end
  end

  // Read data valid in the cycle after the strobe only
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `IONF_OFF_STATUS: rdata_nxt = {24'h0, pfault_r, ref_fail_r, wd_to_r, mismatch,
                                       conflict_r, (st_r == IONF_HALT), drv_en_r,
                                       comm_en};
        `IONF_OFF_RELAY:  rdata_nxt = {23'h0, stat_led_r, relay_r};
        `IONF_OFF_RBACK:  rdata_nxt = {16'h0, relay_rb, rb_err_r};
        `IONF_OFF_DIN:    rdata_nxt = {16'h0, din_r};
        `IONF_OFF_DAC:    rdata_nxt = {16'h0, dac_r};
        `IONF_OFF_ADC:    rdata_nxt = {16'h0, adc_val};
        `IONF_OFF_VFC:    rdata_nxt = {16'h0, count_r};
        `IONF_OFF_ADDR:   rdata_nxt = {24'h0, node_addr_r};
        `IONF_OFF_CFG:    rdata_nxt = cfg_r;
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r        <= IONF_INIT;
      node_addr_r <= 8'h00;
      cfg_r       <= `IONF_CFG_RST;
      relay_r     <= 8'h00;
      dac_r       <= 16'h0000;
      din_r       <= 16'h0000;
      rb_err_r    <= 8'h00;
      conflict_r  <= 1'b0;
      pfault_r    <= 1'b0;
      ref_fail_r  <= 1'b0;
      drv_en_r    <= 1'b0;
      stat_led_r  <= 1'b0;
      wd_cnt_r    <= 32'h0000_0000;
      wd_to_r     <= 1'b0;
      per_cnt_r   <= 16'h0000;
      count_r     <= 16'h0000;
      vfc_d_r     <= 1'b0;
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b0;
      rdata_r     <= 32'h0000_0000;
    end else begin
      st_r        <= st_nxt;
      node_addr_r <= node_addr_nxt;
      cfg_r       <= cfg_nxt;
      relay_r     <= relay_nxt;
      dac_r       <= dac_nxt;
      din_r       <= din_nxt;
      rb_err_r    <= rb_err_nxt;
      conflict_r  <= conflict_nxt;
      pfault_r    <= pfault_nxt;
      ref_fail_r  <= ref_fail_nxt;
      drv_en_r    <= drv_en_nxt;
      stat_led_r  <= stat_led_nxt;
      wd_cnt_r    <= wd_cnt_nxt;
      wd_to_r     <= wd_to_nxt;
      per_cnt_r   <= per_cnt_nxt;
      count_r     <= count_nxt;
      vfc_d_r     <= vfc_d_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_r     <= blink_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign rdata          = rdata_r;
  // Silent on mismatch or conflict so host sees no-message
  assign comm_en        = running && !mismatch && !conflict_r;
  assign outs.drv_en    = drv_en_r;
  assign outs.relay     = relay_r;
  assign outs.stat_led  = stat_led_r;
  assign outs.dac       = dac_r;
  // Steady for processor fault, blinking for halt
  assign outs.fault_led = pfault_r || (st_r == IONF_HALT && blink_r);

  property p_wd_halt;
    @(posedge mclk) disable iff (!resetn)
      (running && is_out && wd_to_r && !host_rst) |=> (st_r == IONF_HALT) && !drv_en_r;
  endproperty
  a_wd_halt: assert property (p_wd_halt) else $error("watchdog did not halt");

  property p_halt_stays;
    @(posedge mclk) disable iff (!resetn)
      (st_r == IONF_HALT && !host_rst) |=> st_r == IONF_HALT;
  endproperty
  a_halt_stays: assert property (p_halt_stays) else $error("halt left early");

  property p_halt_no_drive;
    @(posedge mclk) disable iff (!resetn)
      (st_r == IONF_HALT) |-> !drv_en_r && !comm_en;
  endproperty
  a_halt_no_drive: assert property (p_halt_no_drive) else $error("drive in halt");

  property p_addr_hold;
    @(posedge mclk) disable iff (!resetn)
      (running && !host_rst) |=> $stable(node_addr_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed");

  property p_silent;
    @(posedge mclk) disable iff (!resetn)
      (mismatch || conflict_r) |-> !comm_en;
  endproperty
  a_silent: assert property (p_silent) else $error("node talks on mismatch");

  property p_conflict;
    @(posedge mclk) disable iff (!resetn)
      (running && conflict_r && !host_rst) |=> st_r == IONF_HALT;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not halted");

  property p_wrong_type;
    @(posedge mclk) disable iff (!resetn)
      (cmd_wr && !type_ok && !wd_to_r && !conflict_r && !host_rst) |=> $stable(relay_r)
        && $stable(dac_r);
  endproperty
  a_wrong_type: assert property (p_wrong_type) else $error("wrong type updated");

  property p_load;
    @(posedge mclk) disable iff (!resetn)
      (cmd_wr && type_ok && bus.addr == `IONF_OFF_RELAY && !host_rst && !wd_to_r
        && !conflict_r) |=> relay_r == $past(bus.wdata[7:0]) && wd_cnt_r == 0;
  endproperty
  a_load: assert property (p_load) else $error("relay not loaded");

  property p_hostrst;
    @(posedge mclk) disable iff (!resetn)
      host_rst |=> st_r == IONF_INIT && !wd_to_r ##1 running;
  endproperty
  a_hostrst: assert property (p_hostrst) else $error("host reset failed");

  property p_rb;
    @(posedge mclk) disable iff (!resetn)
      resetn |=> rb_err_r == ($past(relay_rb) ^ $past(relay_r));
  endproperty
  a_rb: assert property (p_rb) else $error("readback compare wrong");

  c_halt:  cover property (@(posedge mclk) disable iff (!resetn) st_r == IONF_HALT);
  c_load:  cover property (@(posedge mclk) disable iff (!resetn) cmd_wr && type_ok);
  c_rst:   cover property (@(posedge mclk) disable iff (!resetn) host_rst && wd_to_r);
  c_ref:   cover property (@(posedge mclk) disable iff (!resetn) ref_fail_r);

endmodule : ionf_node

// ==== tb/ionf_field_model.sv ====
`timescale 1ns/1ps
module ionf_field_model (
  input  wire logic        mclk,
  input  wire logic [7:0]  relays,
  input  wire logic [7:0]  flip,
  input  wire logic [15:0] half,
  output logic [7:0]       relay_rb,
  output logic             vfc_in
);
  logic [15:0] cnt_r = 16'h0000;
  logic        vfc_r = 1'b0;
  // Second contact set follows the coil; flip models a welded contact
  assign relay_rb = relays ^ flip;
  assign vfc_in   = vfc_r;
  // Converter output runs free, period is twice half in mclk cycles
  always @(posedge mclk) begin
    if (cnt_r >= half - 16'h0001) begin
      cnt_r <= 16'h0000;
      vfc_r <= ~vfc_r;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule : ionf_field_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "ionf_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import ionf_pkg::*;
  logic        mclk;
  logic        resetn;
  logic        vfc_ref_sel;
  logic        vfc_in;
  logic        comm_en;
  logic        seen0;
  logic        seen1;
  ionf_bus_t   bus;
  ionf_out_t   outs;
  logic [31:0] rdata;
  logic [7:0]  addr_sw;
  logic [7:0]  relay_rb;
  logic [7:0]  flip;
  logic [15:0] din;
  logic [15:0] adc_val;
  logic [15:0] half;
  int          mismatches;
  int          n_compared;
  int          cyc;

  // Short counts so the watchdog and blink fit in a quick run
  ionf_node #(.WD_CYC(50), .BLINK_CYC(8)) uut (
    .mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata), .addr_sw(addr_sw),
    .relay_rb(relay_rb), .din(din), .adc_val(adc_val), .vfc_in(vfc_in),
    .vfc_ref_sel(vfc_ref_sel), .outs(outs), .comm_en(comm_en)
  );
  ionf_field_model field (
    .mclk(mclk), .relays(outs.relay), .flip(flip), .half(half),
    .relay_rb(relay_rb), .vfc_in(vfc_in)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge mclk);
    bus.wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    @(posedge mclk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge mclk);
    bus.rd   <= 1'b0;
    #1;
    `CHK(nm, e, rdata & m)
  endtask : rd

  // Halt blinks the indicator, so both levels must show up
  task automatic blink_check;
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (20) begin
      @(posedge mclk);
      #1;
      if (outs.fault_led === 1'b0) seen0 = 1'b1;
      if (outs.fault_led === 1'b1) seen1 = 1'b1;
    end
    `CHK("blink", 2'b11, {seen0, seen1})
  endtask : blink_check

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    resetn = 1'b0;
    bus = '0;
    addr_sw = 8'h15;
    din = 16'hA55A;
    adc_val = 16'h1234;
    vfc_ref_sel = 1'b0;
    flip = 8'h00;
    half = 16'h0400;
    idle(10);
    resetn <= 1'b1;
    idle(1);
    addr_sw <= 8'h3C;
    rd("addr", `IONF_OFF_ADDR, 32'hFF, 32'h15);
    rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    wr(`IONF_OFF_CFG, 32'h0000_0215);
    rd("cfg_type", `IONF_OFF_CFG, 32'h700, 32'h200);
    idle(1);
    `CHK("comm_en", 1'b1, comm_en)
    wr(`IONF_OFF_CFG, 32'h0000_0216);
    idle(1);
    `CHK("comm_en", 1'b0, comm_en)
    rd("status", `IONF_OFF_STATUS, 32'h11, 32'h10);
    wr(`IONF_OFF_CFG, 32'h0000_0215);
    wr(`IONF_OFF_RELAY, 32'h0002_01A5);
    idle(1);
    `CHK("relay", 9'h1A5, {outs.stat_led, outs.relay})
    wr(`IONF_OFF_RELAY, 32'h0003_005A);
    idle(1);
    `CHK("relay", 8'hA5, outs.relay)
    flip <= 8'h04;
    idle(2);
    rd("rback", `IONF_OFF_RBACK, 32'hFFFF, 32'hA104);
    rd("din", `IONF_OFF_DIN, 32'hFFFF, 32'hA55A);
    rd("adc", `IONF_OFF_ADC, 32'hFFFF, 32'h1234);
    wr(`IONF_OFF_CFG, 32'h0000_0315);
    repeat (4) begin
      wr(`IONF_OFF_DAC, 32'h0003_0BCD);
      idle(40);
    end
    `CHK("drv_en", 1'b1, outs.drv_en)
    `CHK("dac", 16'h0BCD, outs.dac)
    wr(`IONF_OFF_DAC, 32'h0002_0111);
    idle(1);
    `CHK("dac", 16'h0BCD, outs.dac)
    idle(60);
    `CHK("drv_en", 1'b0, outs.drv_en)
    `CHK("dac", 16'h0000, outs.dac)
    rd("status", `IONF_OFF_STATUS, 32'h26, 32'h24);
    blink_check();
    wr(`IONF_OFF_DAC, 32'h0003_0777);
    idle(1);
    `CHK("dac", 16'h0000, outs.dac)
    wr(`IONF_OFF_CTRL, 32'h1);
    idle(3);
    `CHK("drv_en", 1'b1, outs.drv_en)
    `CHK("fault_led", 1'b0, outs.fault_led)
    rd("addr", `IONF_OFF_ADDR, 32'hFF, 32'h3C);
    wr(`IONF_OFF_CFG, 32'h0000_023C);
    wr(`IONF_OFF_RELAY, 32'h0002_00FF);
    idle(70);
    `CHK("drv_en", 1'b0, outs.drv_en)
    `CHK("relay", 8'h00, outs.relay)
    wr(`IONF_OFF_RELAY, 32'h0002_00FF);
    idle(1);
    `CHK("relay", 8'h00, outs.relay)
    wr(`IONF_OFF_CTRL, 32'h1);
    idle(3);
    `CHK("drv_en", 1'b1, outs.drv_en)
    // Type 0 keeps the watchdog quiet for the long converter runs
    wr(`IONF_OFF_CFG, 32'h0000_003C);
    wr(`IONF_OFF_CTRL, 32'h2);
    idle(1);
    `CHK("comm_en", 1'b0, comm_en)
    rd("conflict", `IONF_OFF_STATUS, 32'h08, 32'h08);
    wr(`IONF_OFF_CTRL, 32'h4);
    idle(1);
    `CHK("fault_led", 1'b1, outs.fault_led)
    rd("latched", `IONF_OFF_STATUS, 32'h88, 32'h88);
    rd("in_type", `IONF_OFF_CFG, 32'h700, 32'h000);
    wr(`IONF_OFF_CTRL, 32'h1);
    idle(3);
    wr(`IONF_OFF_CFG, 32'h0000_003C);
    idle(1);
    `CHK("comm_en", 1'b1, comm_en)
    rd("cleared", `IONF_OFF_STATUS, 32'h98, 32'h00);
    vfc_ref_sel <= 1'b1;
    idle(6000);
    rd("vfc", `IONF_OFF_VFC, 32'hFFFF, 32'h0800);
    rd("ref_ok", `IONF_OFF_STATUS, 32'h40, 32'h00);
    half <= 16'd100;
    idle(1000);
    rd("vfc", `IONF_OFF_VFC, 32'hFFFF, 32'h00C8);
    rd("ref_bad", `IONF_OFF_STATUS, 32'h40, 32'h40);
    // Power cycle in mid-run rereads the switches
    idle(1);
    resetn <= 1'b0;
    idle(2);
    `CHK("drv_en", 1'b0, outs.drv_en)
    addr_sw <= 8'h5A;
    resetn  <= 1'b1;
    idle(2);
    `CHK("drv_en", 1'b1, outs.drv_en)
    rd("addr", `IONF_OFF_ADDR, 32'hFF, 32'h5A);
    rd("cfg_rst", `IONF_OFF_CFG, 32'hFFFFFFFF, `IONF_CFG_RST);
    results();
  end
endmodule : testbench
